// File: src/ramp_pkg.sv
/*
 Shared constants for the output frequency ramp: register map, reset values,
 field codes, state type and timing counts.
 Assumes a 100 MHz control clock and frequencies in steps of 0.01 Hz.
*/
`default_nettype none
package ramp_pkg;
   // ==========================================================
   // widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int FREQ_W = 16;
   localparam int ACC_W = 32;
   localparam int WEIGHT_W = 4;

   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_START_FREQ = 8'h00;
   localparam logic [7:0] OFS_HOLD_TIME = 8'h01;
   localparam logic [7:0] OFS_SHAPE = 8'h02;
   localparam logic [7:0] OFS_BASE_FREQ = 8'h03;
   localparam logic [7:0] OFS_REF_FREQ = 8'h04;
   localparam logic [7:0] OFS_MIN_FREQ = 8'h05;
   localparam logic [7:0] OFS_ACCEL = 8'h06;
   localparam logic [7:0] OFS_DECEL = 8'h07;
   localparam logic [7:0] OFS_ACCEL2 = 8'h08;
   localparam logic [7:0] OFS_DECEL2 = 8'h09;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_OUT_FREQ = 8'h11;

   // ==========================================================
   // status fields
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_HOLD_BIT = 1;
   localparam int STAT_REV_BIT = 2;
   localparam int STAT_SECOND_BIT = 3;

   // ==========================================================
   // reset values (frequency 0.01 Hz, time 0.1 s)
   localparam logic [15:0] RST_START_FREQ = 16'h0032;
   localparam logic [15:0] RST_HOLD_TIME = 16'hFFFF;
   localparam logic [1:0] RST_SHAPE = 2'h0;
   localparam logic [15:0] RST_BASE_FREQ = 16'h1770;
   localparam logic [15:0] RST_REF_FREQ = 16'h1770;
   localparam logic [15:0] RST_MIN_FREQ = 16'h0000;
   localparam logic [15:0] RST_TIME = 16'h0032;
   localparam logic [15:0] RST_DECEL2 = 16'hFFFF;

   // ==========================================================
   // setting limits and codes
   localparam logic [15:0] HOLD_OFF = 16'hFFFF;
   localparam logic [15:0] DECEL2_SAME = 16'hFFFF;
   localparam logic [15:0] HOLD_MAX = 16'h0064;
   localparam logic [15:0] START_MAX = 16'h1770;
   localparam logic [15:0] TIME_MAX = 16'h8CA0;
   localparam logic [15:0] REF_MIN = 16'h0064;
   localparam logic [15:0] REF_MAX = 16'h9C40;
   localparam logic [15:0] START_FLOOR = 16'h0001;
   localparam logic [1:0] SHAPE_LINEAR = 2'h0;
   localparam logic [1:0] SHAPE_S_A = 2'h1;
   localparam logic [1:0] SHAPE_S_B = 2'h2;
   localparam logic [3:0] WEIGHT_FLAT = 4'h8;
   localparam logic [3:0] WEIGHT_ABOVE_BASE = 4'h4;
   localparam logic [3:0] WEIGHT_PAST_SPAN = 4'h3;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 10000;
   localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TENTH_NS = 100000000;
   localparam int TICKS_PER_TENTH = TENTH_NS / TICK_NS;
   localparam int MIN_RAMP_NS = 40000000;
   localparam int MIN_RAMP_TICKS = MIN_RAMP_NS / TICK_NS;

   typedef enum logic [1:0] {ST_STOP, ST_HOLD, ST_RUN} ramp_state_t;
endpackage
`default_nettype wire

// File: src/ramp_if.sv
/*
 Carrier between the ramp controller and its step accumulator.
 Assumes both ends share the control clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface ramp_if;
   logic tick;
   logic active;
   logic [31:0] add;
   logic [31:0] den;
   logic step;
   modport ctrl (output tick, output active, output add, output den, input step);
   modport stepper (input tick, input active, input add, input den, output step);
endinterface
`default_nettype wire

// File: src/ramp_stepper.sv
/*
 Step accumulator: adds the weighted rate once per tick and emits one
 0.01 Hz step pulse per cycle while the sum is at or above the denominator.
 Assumes den is never zero and steps per tick stay well under a tick.
*/
`timescale 1ns/100ps
`default_nettype none
module ramp_stepper
   import ramp_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // controller side
   ramp_if.stepper rif
);
   logic [ACC_W-1:0] acc;
   wire logic [ACC_W-1:0] acc_sum = acc + rif.add;
   wire logic acc_over = acc >= rif.den;

   // ==========================================================
   // accumulator
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         acc <= '0;
         rif.step <= 1'b0;
      end else begin
         rif.step <= 1'b0;
         if (!rif.active) begin
            acc <= '0;
         end else if (rif.tick) begin
            acc <= acc_sum;
         end else if (acc_over) begin
            acc <= acc - rif.den;
            rif.step <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: src/shape_weight.sv
/*
 S-curve rate weight: progress covered/span in eighths selects a weight
 whose mean over the span is the flat weight of eight.
 Assumes span is non-zero while the weight is used.
*/
`timescale 1ns/100ps
`default_nettype none
module shape_weight
   import ramp_pkg::*;
#(
   parameter int STEPS = 8
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // progress
   input wire logic [FREQ_W-1:0] covered_in,
   input wire logic [FREQ_W-1:0] span_in,
   input wire logic [WEIGHT_W-1:0] beyond_in,
   // weight
   output logic [WEIGHT_W-1:0] weight_out
);
   logic [STEPS-2:0] past;
   logic [3:0] idx;
   logic [WEIGHT_W-1:0] next_weight;
   wire logic [FREQ_W+2:0] covered_x8 = {covered_in, 3'b000};

   // ==========================================================
   // one comparator per inner boundary between eighths of the span
   genvar k;
   generate
      for (k = 1; k < STEPS; k++) begin : g_cmp
         assign past[k-1] = covered_x8 >= (FREQ_W+3)'(k * span_in);
      end
   endgenerate

   always_comb begin
      idx = 4'h0;
      for (int i = 0; i < STEPS - 1; i++) begin
         idx = idx + 4'(past[i]);
      end
      case (idx)
         4'h0, 4'h7: next_weight = 4'h3;
         4'h1, 4'h6: next_weight = 4'h7;
         4'h2, 4'h5: next_weight = 4'hA;
         4'h3, 4'h4: next_weight = 4'hC;
         default: next_weight = 4'h3;
      endcase
      // slow end of the curve must never stall the ramp at zero weight
      if (covered_in >= span_in) begin
         next_weight = beyond_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         weight_out <= WEIGHT_FLAT;
      end else begin
         weight_out <= next_weight;
      end
   end
endmodule
`default_nettype wire

// File: src/output_frequency_ramp.sv
/*
 Output frequency command generator: start frequency gate, start hold,
 and linear or S-curve ramps toward the commanded frequency.
 Assumes all inputs synchronous to clk_in and a plain register port with
 read data one cycle after the read strobe.
*/
// Implementation choices: strobed register access and the placing of the registers.
// Summary of operation
// - stay stopped until command reaches start frequency
// - hold start frequency for hold time after start
// - zero start frequency holds at 0.01 Hz
// - start removed during hold decelerates at once
// - direction change uses start frequency, no hold
// - start below minimum runs at preset frequency
// - shape 0 linear, 1 S-A, 2 S-B
// - linear mode uses constant frequency slope
// - S-curve A inflects at base frequency
// - S-curve A time refers to base frequency
// - S-curve B shapes each change from present
// - ramp time means zero to reference frequency
// - second function selects second ramp times
// - start frequency limited to 0 to 60 Hz
`timescale 1ns/100ps
`default_nettype none
module output_frequency_ramp
   import ramp_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES,
   parameter int TENTH_TICKS = TICKS_PER_TENTH,
   parameter int MIN_TICKS = MIN_RAMP_TICKS
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // register port
   input wire logic [ramp_pkg::ADDR_W-1:0] addr_in,
   input wire logic [ramp_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [ramp_pkg::DATA_W-1:0] rdata_out,
   // run inputs
   input wire logic start_in,
   input wire logic reverse_in,
   input wire logic second_function_select_in,
   input wire logic [ramp_pkg::FREQ_W-1:0] freq_command_in,
   // drive command
   output logic [ramp_pkg::FREQ_W-1:0] out_freq_out,
   output logic reverse_out,
   output logic running_out,
   output logic holding_out
);
   // ==========================================================
   // settings
   logic [15:0] start_frequency_setting;
   logic [15:0] start_hold_time;
   logic [1:0] ramp_shape_select;
   logic [15:0] base_frequency_setting;
   logic [15:0] ramp_reference_frequency;
   logic [15:0] minimum_frequency_setting;
   logic [15:0] accel_time_setting;
   logic [15:0] decel_time_setting;
   logic [15:0] accel_time_second;
   logic [15:0] decel_time_second;

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   wire logic wr_start = wr_in && (addr_in == OFS_START_FREQ);
   wire logic wr_hold = wr_in && (addr_in == OFS_HOLD_TIME);
   wire logic wr_shape = wr_in && (addr_in == OFS_SHAPE);
   wire logic wr_base = wr_in && (addr_in == OFS_BASE_FREQ);
   wire logic wr_ref = wr_in && (addr_in == OFS_REF_FREQ);
   wire logic wr_min = wr_in && (addr_in == OFS_MIN_FREQ);
   wire logic wr_acc = wr_in && (addr_in == OFS_ACCEL);
   wire logic wr_dec = wr_in && (addr_in == OFS_DECEL);
   wire logic wr_acc2 = wr_in && (addr_in == OFS_ACCEL2);
   wire logic wr_dec2 = wr_in && (addr_in == OFS_DECEL2);
   // shape codes beyond the three patterns are refused, old pattern kept
   wire logic shape_ok = wdata_in[15:0] <= 16'(SHAPE_S_B);
   // hold accepts 0..10 s, or the all-ones code that disables it
   wire logic [15:0] hold_wval = (wdata_in == HOLD_OFF) ? HOLD_OFF : clamp(wdata_in, 16'h0000, HOLD_MAX);
   wire logic [15:0] dec2_wval = (wdata_in == DECEL2_SAME) ? DECEL2_SAME : clamp(wdata_in, 16'h0000, TIME_MAX);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         start_frequency_setting <= RST_START_FREQ;
         start_hold_time <= RST_HOLD_TIME;
         ramp_shape_select <= RST_SHAPE;
         base_frequency_setting <= RST_BASE_FREQ;
         ramp_reference_frequency <= RST_REF_FREQ;
         minimum_frequency_setting <= RST_MIN_FREQ;
         accel_time_setting <= RST_TIME;
         decel_time_setting <= RST_TIME;
         accel_time_second <= RST_TIME;
         decel_time_second <= RST_DECEL2;
      end else begin
         if (wr_start) start_frequency_setting <= clamp(wdata_in, 16'h0000, START_MAX);
         if (wr_hold) start_hold_time <= hold_wval;
         if (wr_shape && shape_ok) ramp_shape_select <= wdata_in[1:0];
         if (wr_base) base_frequency_setting <= clamp(wdata_in, REF_MIN, REF_MAX);
         if (wr_ref) ramp_reference_frequency <= clamp(wdata_in, REF_MIN, REF_MAX);
         if (wr_min) minimum_frequency_setting <= clamp(wdata_in, 16'h0000, REF_MAX);
         if (wr_acc) accel_time_setting <= clamp(wdata_in, 16'h0000, TIME_MAX);
         if (wr_dec) decel_time_setting <= clamp(wdata_in, 16'h0000, TIME_MAX);
         if (wr_acc2) accel_time_second <= clamp(wdata_in, 16'h0000, TIME_MAX);
         if (wr_dec2) decel_time_second <= dec2_wval;
      end
   end

   // ==========================================================
   // control tick
   logic [15:0] tick_cnt;
   wire logic tick_now = tick_cnt == 16'(TICK_LEN - 1);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tick_cnt <= 16'h0000;
      end else begin
         tick_cnt <= tick_now ? 16'h0000 : tick_cnt + 16'h0001;
      end
   end

   // ==========================================================
   // run decision and target
   ramp_state_t state;
   ramp_state_t next_state;
   logic [15:0] freq;
   logic [15:0] next_freq;
   logic dir;
   logic next_dir;
   logic [31:0] hold_cnt;
   logic [31:0] next_hold_cnt;
   logic [15:0] seg_start;
   logic [15:0] target_q;

   // preset frequency applies when the start gate sits at or under minimum
   wire logic gate_open = start_frequency_setting <= minimum_frequency_setting;
   wire logic cmd_reached = freq_command_in >= start_frequency_setting;
   wire logic run_ok = start_in && (cmd_reached || gate_open);
   wire logic [15:0] cmd_eff = (freq_command_in < minimum_frequency_setting) ?
                               minimum_frequency_setting : freq_command_in;
   wire logic dir_match = reverse_in == dir;
   wire logic [15:0] target = (run_ok && dir_match) ? cmd_eff : 16'h0000;
   wire logic [15:0] start_value = (start_frequency_setting == 16'h0000) ?
                                   START_FLOOR : start_frequency_setting;
   wire logic hold_on = start_hold_time != HOLD_OFF;
   wire logic [31:0] hold_limit = 32'(start_hold_time) * 32'(TENTH_TICKS);
   wire logic hold_done = hold_cnt >= hold_limit;

   // ==========================================================
   // ramp time and rate
   wire logic going_up = target > freq;
   wire logic [15:0] dec2_eff = (decel_time_second == DECEL2_SAME) ? accel_time_second : decel_time_second;
   wire logic [15:0] time_up = second_function_select_in ? accel_time_second : accel_time_setting;
   wire logic [15:0] time_dn = second_function_select_in ? dec2_eff : decel_time_setting;
   wire logic [15:0] time_sel = going_up ? time_up : time_dn;
   wire logic [31:0] time_ticks = 32'(time_sel) * 32'(TENTH_TICKS);
   // very short settings fall back to the shortest ramp the drive allows
   wire logic [31:0] ramp_ticks = (time_ticks < 32'(MIN_TICKS)) ? 32'(MIN_TICKS) : time_ticks;
   // S-curve A measures its time to base frequency instead of reference
   wire logic [15:0] rate_ref = (ramp_shape_select == SHAPE_S_A) ?
                                base_frequency_setting : ramp_reference_frequency;

   // S-curve A: progress from zero toward base frequency
   logic [3:0] weight_a;
   shape_weight #(
      .STEPS(8)
   ) u_weight_a (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .covered_in(freq),
      .span_in(base_frequency_setting),
      .beyond_in(WEIGHT_ABOVE_BASE),
      .weight_out(weight_a)
   );

   // S-curve B: progress from the segment start toward the target
   wire logic [15:0] span_b = (target_q > seg_start) ? target_q - seg_start : seg_start - target_q;
   wire logic [15:0] cover_b = (freq > seg_start) ? freq - seg_start : seg_start - freq;
   logic [3:0] weight_b;
   shape_weight #(
      .STEPS(8)
   ) u_weight_b (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .covered_in(cover_b),
      .span_in(span_b),
      .beyond_in(WEIGHT_PAST_SPAN),
      .weight_out(weight_b)
   );

   wire logic [3:0] weight = (ramp_shape_select == SHAPE_S_A) ? weight_a :
                             (ramp_shape_select == SHAPE_S_B) ? weight_b : WEIGHT_FLAT;

   // ==========================================================
   // step accumulator
   ramp_if rif ();
   ramp_stepper u_stepper (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .rif(rif)
   );
   // weight averages eight, so the denominator carries the same factor
   assign rif.tick = tick_now;
   assign rif.active = (state == ST_RUN) && (freq != target);
   assign rif.add = 32'(weight) * 32'(rate_ref);
   assign rif.den = {ramp_ticks[28:0], 3'b000};

   // ==========================================================
   // sequencer
   always_comb begin
      next_state = state;
      next_freq = freq;
      next_dir = dir;
      next_hold_cnt = hold_cnt;
      case (state)
         ST_STOP: begin
            next_freq = 16'h0000;
            next_hold_cnt = 32'h0000_0000;
            if (run_ok) begin
               next_dir = reverse_in;
               next_freq = start_value;
               next_state = hold_on ? ST_HOLD : ST_RUN;
            end
         end
         ST_HOLD: begin
            if (!start_in) begin
               next_state = ST_RUN;
            end else if (hold_done) begin
               next_state = ST_RUN;
            end else if (tick_now) begin
               next_hold_cnt = hold_cnt + 32'h0000_0001;
            end
         end
         ST_RUN: begin
            if (rif.step && going_up) begin
               next_freq = freq + 16'h0001;
            end else if (rif.step && (freq > target)) begin
               next_freq = freq - 16'h0001;
            end else if (freq == 16'h0000) begin
               if (run_ok && !dir_match) begin
                  next_dir = reverse_in;
                  next_freq = start_value;
               end else if (!run_ok) begin
                  next_state = ST_STOP;
               end
            end
         end
         default: begin
            next_state = ST_STOP;
            next_freq = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= ST_STOP;
         freq <= 16'h0000;
         dir <= 1'b0;
         hold_cnt <= 32'h0000_0000;
      end else begin
         state <= next_state;
         freq <= next_freq;
         dir <= next_dir;
         hold_cnt <= next_hold_cnt;
      end
   end

   // new segment whenever the target moves or the ramp is idle
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         seg_start <= 16'h0000;
         target_q <= 16'h0000;
      end else begin
         target_q <= target;
         if ((target != target_q) || !rif.active) begin
            seg_start <= freq;
         end
      end
   end

   // ==========================================================
   // outputs
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         out_freq_out <= 16'h0000;
         reverse_out <= 1'b0;
         running_out <= 1'b0;
         holding_out <= 1'b0;
      end else begin
         out_freq_out <= next_freq;
         reverse_out <= next_dir;
         running_out <= next_state != ST_STOP;
         holding_out <= next_state == ST_HOLD;
      end
   end

   // ==========================================================
   // register read
   logic [15:0] status_word;
   logic [15:0] read_mux;

   always_comb begin
      status_word = 16'h0000;
      status_word[STAT_RUN_BIT] = state != ST_STOP;
      status_word[STAT_HOLD_BIT] = state == ST_HOLD;
      status_word[STAT_REV_BIT] = dir;
      status_word[STAT_SECOND_BIT] = second_function_select_in;
      case (addr_in)
         OFS_START_FREQ: read_mux = start_frequency_setting;
         OFS_HOLD_TIME: read_mux = start_hold_time;
         OFS_SHAPE: read_mux = {14'h0000, ramp_shape_select};
         OFS_BASE_FREQ: read_mux = base_frequency_setting;
         OFS_REF_FREQ: read_mux = ramp_reference_frequency;
         OFS_MIN_FREQ: read_mux = minimum_frequency_setting;
         OFS_ACCEL: read_mux = accel_time_setting;
         OFS_DECEL: read_mux = decel_time_setting;
         OFS_ACCEL2: read_mux = accel_time_second;
         OFS_DECEL2: read_mux = decel_time_second;
         OFS_STATUS: read_mux = status_word;
         OFS_OUT_FREQ: read_mux = freq;
         default: read_mux = 16'h0000;
      endcase
   end

   // read data shows only in the cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rdata_out <= 16'h0000;
      end else begin
         rdata_out <= rd_in ? read_mux : 16'h0000;
      end
   end
endmodule
`default_nettype wire

// File: verification/output_frequency_ramp_properties.sv
/* checker for output_frequency_ramp: stop, start, hold and step relations.
   assumes it sees only top-level ports, via bind */
`timescale 1ns/100ps
`default_nettype none
module output_frequency_ramp_properties
   import ramp_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES,
   parameter int TENTH_TICKS = TICKS_PER_TENTH
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // watched ports
   input wire logic start_in,
   input wire logic [ramp_pkg::FREQ_W-1:0] out_freq_out,
   input wire logic reverse_out,
   input wire logic running_out,
   input wire logic holding_out
);
   // ==========
   // helpers
   localparam int HOLD_LIMIT = (HOLD_MAX * TENTH_TICKS + 1) * TICK_LEN;
   logic [15:0] hold_len;
   always_ff @(posedge clk_in) begin
      if (reset_in || !holding_out) begin
         hold_len <= 16'h0000;
      end else begin
         hold_len <= hold_len + 16'h0001;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence run_begins;
      !running_out ##1 running_out;
   endsequence
   sequence run_ends;
      running_out ##1 !running_out;
   endsequence
   // ==========
   // properties
   stop_zero_a: assert property (!running_out |-> out_freq_out == 16'h0000)
      else $error("output nonzero while stopped");
   run_begin_a: assert property (run_begins |-> out_freq_out != 16'h0000)
      else $error("run began at zero");
   hold_steady_a: assert property (holding_out && $past(holding_out) |-> $stable(out_freq_out))
      else $error("output moved during hold");
   hold_abandon_a: assert property (holding_out && !start_in |=> !holding_out)
      else $error("hold kept after start dropped");
   hold_bound_a: assert property (hold_len <= HOLD_LIMIT)
      else $error("hold beyond longest hold time");
   step_one_a: assert property (running_out && $past(running_out) && $past(out_freq_out) != 16'h0000
      |-> out_freq_out - $past(out_freq_out) <= 16'h0001 || $past(out_freq_out) - out_freq_out <= 16'h0001)
      else $error("output stepped by more than one");
   rev_no_hold_a: assert property ($changed(reverse_out) && $past(running_out) |-> !holding_out)
      else $error("hold after direction change");
   stop_at_zero_a: assert property (run_ends |-> $past(out_freq_out) == 16'h0000)
      else $error("stopped above zero");
endmodule
bind output_frequency_ramp output_frequency_ramp_properties #(.TICK_LEN(TICK_LEN), .TENTH_TICKS(TENTH_TICKS))
   props (.clk_in(clk_in), .reset_in(reset_in), .start_in(start_in), .out_freq_out(out_freq_out),
   .reverse_out(reverse_out), .running_out(running_out), .holding_out(holding_out));
`default_nettype wire

// File: verification/run_source.sv
/* far-side model: start, direction, second select and frequency command.
   assumes the bench calls drive; changes land after a rising edge */
`timescale 1ns/100ps
`default_nettype none
module run_source (
   // clock
   input wire logic clk_in,
   // run inputs
   output logic start_out = 1'b0,
   output logic reverse_out = 1'b0,
   output logic select_out = 1'b0,
   output logic [15:0] command_out = 16'h0000
);
   // ==========
   // level drive
   task automatic drive(input logic s, r, f, input logic [15:0] c);
      @(posedge clk_in);
      start_out <= s;
      reverse_out <= r;
      select_out <= f;
      command_out <= c;
   endtask
endmodule
`default_nettype wire

// File: verification/output_frequency_ramp_bench.sv
/* self-checking bench for output_frequency_ramp.
   assumes scaled tick counts: 4-cycle tick, 10 ticks a tenth second */
`timescale 1ns/100ps
`default_nettype none
module output_frequency_ramp_bench;
   import ramp_pkg::*;
   // ==========
   // signals
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [15:0] wdata_in = 16'h0000;
   logic [15:0] rdata_out, out_freq_out, cmd;
   logic start, rev, sel, reverse_out, running_out, holding_out;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;
   int lo[3] = '{112, 40, 130};
   int hi[3] = '{130, 110, 200};
   always #5 clk_in = ~clk_in;
   run_source src (.clk_in(clk_in), .start_out(start), .reverse_out(rev), .select_out(sel), .command_out(cmd));
   output_frequency_ramp #(.TICK_LEN(4), .TENTH_TICKS(10), .MIN_TICKS(4)) dut (.clk_in(clk_in),
      .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .start_in(start), .reverse_in(rev), .second_function_select_in(sel),
      .freq_command_in(cmd), .out_freq_out(out_freq_out), .reverse_out(reverse_out),
      .running_out(running_out), .holding_out(holding_out));
   // ==========
   // tasks
   task automatic cmp(input string what, input logic [15:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_bit(input string what, input logic exp, got);
      cmp(what, {15'h0000, exp}, {15'h0000, got});
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 cmp("rdata", exp, rdata_out);
   endtask
   // bounded wait, returns cycles taken
   task automatic reach(input logic [15:0] f, output int k);
      k = 0;
      while (out_freq_out !== f && k < 1000) begin
         @(posedge clk_in);
         #1 k++;
      end
      cmp("out_freq", f, out_freq_out);
   endtask
   task automatic halt();
      src.drive(1'b0, 1'b0, 1'b0, 16'h0000);
      reach(16'h0000, n);
      repeat (2) @(posedge clk_in);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   // ==========
   // tests
   initial begin
      repeat (6) @(posedge clk_in);
      reset_in <= 1'b0;
      rd(OFS_START_FREQ, RST_START_FREQ);
      rd(OFS_HOLD_TIME, RST_HOLD_TIME);
      rd(OFS_SHAPE, 16'h0000);
      rd(OFS_ACCEL, RST_TIME);
      rd(8'h0A, 16'h0000);
      wr(OFS_SHAPE, 16'h0003);
      rd(OFS_SHAPE, 16'h0000);
      wr(OFS_START_FREQ, 16'hFFFF);
      rd(OFS_START_FREQ, START_MAX);
      $display("registers done");
      wr(OFS_START_FREQ, 16'h0032);
      wr(OFS_REF_FREQ, 16'h0064);
      wr(OFS_BASE_FREQ, 16'h0064);
      wr(OFS_ACCEL, 16'h000A);
      wr(OFS_DECEL, 16'h000A);
      src.drive(1'b1, 1'b0, 1'b0, 16'h0028);
      repeat (20) @(posedge clk_in);
      #1 cmp_bit("running", 1'b0, running_out);
      for (int s = 0; s < 3; s++) begin
         wr(OFS_SHAPE, 16'(s));
         src.drive(1'b1, 1'b0, 1'b0, 16'h0050);
         reach(16'h0050, n);
         cmp_bit("ramp_len", 1'b1, n >= lo[s] && n <= hi[s]);
         halt();
      end
      $display("shapes done");
      wr(OFS_SHAPE, 16'h0000);
      wr(OFS_HOLD_TIME, 16'h0001);
      src.drive(1'b1, 1'b0, 1'b0, 16'h0050);
      repeat (30) @(posedge clk_in);
      #1 cmp("hold_out", 16'h0032, out_freq_out);
      cmp_bit("holding", 1'b1, holding_out);
      repeat (16) @(posedge clk_in);
      #1 cmp_bit("holding", 1'b0, holding_out);
      halt();
      src.drive(1'b1, 1'b0, 1'b0, 16'h0050);
      repeat (10) @(posedge clk_in);
      src.drive(1'b0, 1'b0, 1'b0, 16'h0050);
      repeat (2) @(posedge clk_in);
      #1 cmp_bit("holding", 1'b0, holding_out);
      reach(16'h0000, n);
      repeat (2) @(posedge clk_in);
      wr(OFS_START_FREQ, 16'h0000);
      src.drive(1'b1, 1'b0, 1'b0, 16'h0050);
      repeat (2) @(posedge clk_in);
      #1 cmp("start_out", 16'h0001, out_freq_out);
      halt();
      wr(OFS_START_FREQ, 16'h0032);
      $display("hold done");
      src.drive(1'b1, 1'b0, 1'b0, 16'h0050);
      reach(16'h0050, n);
      src.drive(1'b1, 1'b1, 1'b0, 16'h0050);
      reach(16'h0000, n);
      reach(16'h0032, n);
      cmp_bit("reverse", 1'b1, reverse_out);
      cmp_bit("holding", 1'b0, holding_out);
      halt();
      wr(OFS_MIN_FREQ, 16'h003C);
      src.drive(1'b1, 1'b0, 1'b0, 16'h0000);
      reach(16'h003C, n);
      halt();
      wr(OFS_MIN_FREQ, 16'h0000);
      $display("direction and preset done");
      wr(OFS_HOLD_TIME, 16'hFFFF);
      wr(OFS_ACCEL2, 16'h0005);
      src.drive(1'b1, 1'b0, 1'b1, 16'h0050);
      reach(16'h0050, n);
      cmp_bit("second_len", 1'b1, n > 52 && n < 68);
      rd(OFS_STATUS, 16'h0009);
      rd(OFS_OUT_FREQ, 16'h0050);
      halt();
      $display("second set done");
      wrap_up();
   end
endmodule
`default_nettype wire
